//--- verilog/gst_pkg.sv
// package: constants and types for the gated sixteen-bit timer core
// Operation
// - sixteen-bit up-counter read as two bytes
// - byte writes replace live counter part
// - fosc/4 source counts once per instruction cycle, fosc source every clock
// - external source counts each rising edge once armed by a low level
// - run off stops; gate enable qualifies counting
// - selectable gate sources with configurable polarity
// - overflow wakes only in async external mode
// - clock select picks fosc, fosc/4, cap, external
// - prescaler 1/2/4/8, cleared by count writes
// - gated count only while gate matches polarity
// - gate source select: pin, tmr0, cmp1, cmp2
package gst_pkg;
  // ----------------------------------------------------------------
  // widths and encodings
  // ----------------------------------------------------------------
  localparam int COUNT_WIDTH = 16;
  localparam int BYTE_WIDTH  = 8;
  localparam logic [1:0] CS_INSTR = 2'h0;  // fosc/4
  localparam logic [1:0] CS_SYS   = 2'h1;  // fosc
  localparam logic [1:0] CS_EXT   = 2'h2;  // pin or crystal
  localparam logic [1:0] CS_CAP   = 2'h3;  // cap sensing osc
  localparam logic [1:0] GS_PIN   = 2'h0;
  localparam logic [1:0] GS_TMR0  = 2'h1;
  localparam logic [1:0] GS_CMP1  = 2'h2;
  localparam logic [1:0] GS_CMP2  = 2'h3;
  localparam logic [1:0] INSTR_DIV_LAST = 2'h3;  // four system clocks per instruction
  localparam logic [COUNT_WIDTH-1:0] COUNT_RESET = 16'h0000;
  localparam logic [COUNT_WIDTH-1:0] COUNT_ALL_ONES = 16'hFFFF;
  localparam logic [2:0] PRESCALE_RESET = 3'h0;
  // edge tracking state of the external count input
  typedef enum logic [1:0] {
    GST_ARM_WAIT = 2'b01,  // waiting for a low level before first rise
    GST_ARM_READY = 2'b10  // a low level seen, rises count
  } gst_arm_t;
endpackage : gst_pkg

//--- verilog/gst_tick_if.sv
// interface: tick and clear between the core and its prescaler
`timescale 1ns/10ps
`default_nettype none
interface gst_tick_if;
  logic       tick_in;   // qualified source tick
  logic       clear;     // prescaler clear on count write
  logic [1:0] ratio;     // prescale_select
  logic       tick_out;  // divided tick into counter
  modport core (output tick_in, output clear, output ratio, input tick_out);
  modport pre  (input tick_in, input clear, input ratio, output tick_out);
endinterface : gst_tick_if
`default_nettype wire

//--- verilog/gst_prescaler.sv
// module: 1/2/4/8 prescaler in front of the counter
`timescale 1ns/10ps
`default_nettype none
module gst_prescaler
  import gst_pkg::*;
(
  // clock and reset
  input  wire logic clk,
  input  wire logic srst,
  // link to the core
  gst_tick_if.pre   tk
);
  // ----------------------------------------------------------------
  // prescale counter (not visible to software)
  // ----------------------------------------------------------------
  logic [2:0] pcount;  // free prescale count
  logic [2:0] mask;    // bits that must be all ones to pass a tick

  // mask from ratio: 1->000, 2->001, 4->011, 8->111
  always_comb begin
    case (tk.ratio)
      2'h0:    mask = 3'h0;
      2'h1:    mask = 3'h1;
      2'h2:    mask = 3'h3;
      default: mask = 3'h7;
    endcase
  end

  // tick passes when the selected low bits are all ones
  assign tk.tick_out = tk.tick_in && ((pcount & mask) == mask);

  // counter advances per input tick, clears on count writes
  always_ff @(posedge clk) begin
    if (srst || tk.clear) begin
      pcount <= PRESCALE_RESET;
    end else if (tk.tick_in) begin
      pcount <= pcount + 3'h1;
    end
  end
endmodule : gst_prescaler
`default_nettype wire

//--- verilog/gst_timer_core.sv
// module: gated sixteen-bit timer core top level
`timescale 1ns/10ps
`default_nettype none
module gst_timer_core
  import gst_pkg::*;
#(
  parameter int CW = COUNT_WIDTH
) (
  // clock and reset
  input  wire logic                  clk,
  input  wire logic                  srst,
  // software count access
  input  wire logic                  count_high_byte_we,
  input  wire logic                  count_low_byte_we,
  input  wire logic [BYTE_WIDTH-1:0] count_wdata,
  output logic      [BYTE_WIDTH-1:0] count_high_byte,
  output logic      [BYTE_WIDTH-1:0] count_low_byte,
  // counter_control bits
  input  wire logic                  counter_run,
  input  wire logic [1:0]            count_clock_select,
  input  wire logic                  crystal_osc_enable,
  input  wire logic [1:0]            prescale_select,
  input  wire logic                  async_mode,
  // gate_control bits
  input  wire logic                  gate_count_enable,
  input  wire logic                  gate_polarity,
  input  wire logic [1:0]            gate_source_select,
  output logic                       gate_value,
  // external sources
  input  wire logic                  external_count_pin,
  input  wire logic                  crystal_osc_clk,
  input  wire logic                  cap_sense_osc,
  input  wire logic                  gate_input_pin,
  input  wire logic                  tmr0_overflow,
  input  wire logic                  first_comparator_out,
  input  wire logic                  second_comparator_out,
  // flags and events
  input  wire logic                  overflow_clear,
  input  wire logic                  overflow_int_enable,
  input  wire logic                  gate_event_clear,
  input  wire logic                  sleep_mode,
  output logic                       overflow_flag,
  output logic                       overflow_irq,
  output logic                       gate_event_flag,
  output logic                       wake_request
);
  // ----------------------------------------------------------------
  // synchronisers for pin-side inputs
  // ----------------------------------------------------------------
  localparam int NSYNC = 6;
  logic [NSYNC-1:0] raw_in;    // asynchronous sources
  logic [NSYNC-1:0] s1, s2, s3;  // three-stage chains
  logic [NSYNC-1:0] clean;     // settled level, changes when s2 and s3 agree
  assign raw_in = {second_comparator_out, first_comparator_out, gate_input_pin,
                   cap_sense_osc, crystal_osc_clk, external_count_pin};

  // s1 is read only by s2
  always_ff @(posedge clk) begin
    if (srst) begin
      s1 <= '0;
      s2 <= '0;
      s3 <= '0;
    end else begin
      s1 <= raw_in;
      s2 <= s1;
      s3 <= s2;
    end
  end

  // accept a new level only once the last two stages agree
  genvar gi;
  generate
    for (gi = 0; gi < NSYNC; gi++) begin : g_clean
      always_ff @(posedge clk) begin
        if (srst) begin
          clean[gi] <= 1'b0;
        end else if (s2[gi] == s3[gi]) begin
          clean[gi] <= s3[gi];
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // gate selection and status
  // ----------------------------------------------------------------
  logic gate_src;      // selected gate source
  logic gate_open;     // source matches polarity
  logic gate_open_d;   // previous value, for event detection

  always_comb begin
    case (gate_source_select)
      GS_PIN:  gate_src = clean[3];
      GS_TMR0: gate_src = tmr0_overflow;  // same-clock pulse, no sync
      GS_CMP1: gate_src = clean[4];
      GS_CMP2: gate_src = clean[5];
      default: gate_src = 1'b0;
    endcase
  end
  assign gate_open = (gate_src == gate_polarity);

  // gate value status is registered
  always_ff @(posedge clk) begin
    if (srst) begin
      gate_value  <= 1'b0;
      gate_open_d <= 1'b0;
    end else begin
      gate_value  <= gate_src;
      gate_open_d <= gate_open;
    end
  end

  // gate event: gate closes while gating is in use; set beats clear
  always_ff @(posedge clk) begin
    if (srst) begin
      gate_event_flag <= 1'b0;
    end else if (counter_run && gate_count_enable && gate_open_d && !gate_open) begin
      gate_event_flag <= 1'b1;
    end else if (gate_event_clear) begin
      gate_event_flag <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // enable and source tick
  // ----------------------------------------------------------------
  logic count_enable;  // run and gate combined
  always_comb begin
    if (!counter_run) begin
      count_enable = 1'b0;
    end else if (!gate_count_enable) begin
      count_enable = 1'b1;
    end else begin
      count_enable = gate_open;
    end
  end

  // instruction-cycle divider, four system clocks each
  logic [1:0] instr_div;
  always_ff @(posedge clk) begin
    if (srst) begin
      instr_div <= 2'h0;
    end else begin
      instr_div <= instr_div + 2'h1;
    end
  end

  // external edge source and its arming state
  logic     ext_level;    // chosen external level
  logic     ext_level_d;  // previous sample
  gst_arm_t arm;          // low level needed before the first rise
  logic     count_write;  // either byte written
  assign ext_level   = crystal_osc_enable ? clean[1] : clean[0];
  assign count_write = count_high_byte_we || count_low_byte_we;

  always_ff @(posedge clk) begin
    if (srst) begin
      ext_level_d <= 1'b0;
    end else begin
      ext_level_d <= (count_clock_select == CS_CAP) ? clean[2] : ext_level;
    end
  end

  // the first rise after a write or while stopped must follow a low level
  always_ff @(posedge clk) begin
    if (srst || count_write || !counter_run) begin
      arm <= GST_ARM_WAIT;
    end else begin
      case (arm)
        GST_ARM_WAIT:  arm <= ext_level_d ? GST_ARM_WAIT : GST_ARM_READY;
        GST_ARM_READY: arm <= GST_ARM_READY;
        default:       arm <= GST_ARM_WAIT;
      endcase
    end
  end

  logic cur_ext;     // current external level by selection
  logic ext_rise;    // armed rising edge
  logic src_tick;    // raw tick before prescaling
  assign cur_ext  = (count_clock_select == CS_CAP) ? clean[2] : ext_level;
  assign ext_rise = cur_ext && !ext_level_d && (arm == GST_ARM_READY);

  always_comb begin
    case (count_clock_select)
      CS_INSTR: src_tick = (instr_div == INSTR_DIV_LAST);
      CS_SYS:   src_tick = 1'b1;
      CS_EXT:   src_tick = ext_rise;
      CS_CAP:   src_tick = ext_rise;
      default:  src_tick = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------
  // prescaler
  // ----------------------------------------------------------------
  gst_tick_if tk ();
  assign tk.tick_in = src_tick && count_enable;
  assign tk.clear   = count_write;
  assign tk.ratio   = prescale_select;

  gst_prescaler u_pre (
    .clk  (clk),
    .srst (srst),
    .tk   (tk)
  );

  // ----------------------------------------------------------------
  // counter with byte write access
  // ----------------------------------------------------------------
  logic [CW-1:0] count;       // live count
  logic [CW-1:0] next_count;
  logic          wrap;        // increment from all ones
  assign wrap = tk.tick_out && (count == COUNT_ALL_ONES[CW-1:0]);

  always_comb begin
    next_count = count;
    if (tk.tick_out) begin
      next_count = count + {{(CW-1){1'b0}}, 1'b1};
    end
    if (count_high_byte_we) begin
      next_count[CW-1 -: BYTE_WIDTH] = count_wdata;
    end
    if (count_low_byte_we) begin
      next_count[BYTE_WIDTH-1:0] = count_wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      count <= COUNT_RESET[CW-1:0];
    end else begin
      count <= next_count;
    end
  end
  assign count_high_byte = count[CW-1 -: BYTE_WIDTH];
  assign count_low_byte  = count[BYTE_WIDTH-1:0];

  // ----------------------------------------------------------------
  // overflow flag, interrupt and wake
  // ----------------------------------------------------------------
  // a wrap in the clear cycle keeps the flag set
  always_ff @(posedge clk) begin
    if (srst) begin
      overflow_flag <= 1'b0;
    end else if (wrap && !count_write) begin
      overflow_flag <= 1'b1;
    end else if (overflow_clear) begin
      overflow_flag <= 1'b0;
    end
  end
  assign overflow_irq = overflow_flag && overflow_int_enable;

  // wake only from asynchronous external counting
  always_ff @(posedge clk) begin
    if (srst) begin
      wake_request <= 1'b0;
    end else begin
      wake_request <= sleep_mode && overflow_irq && async_mode
                      && (count_clock_select == CS_EXT);
    end
  end
endmodule : gst_timer_core
`default_nettype wire

//--- test/gst_source_model.sv
// model: external count clocks and gate pin seen by the timer core
`timescale 1ns/10ps
`default_nettype none
module gst_source_model (
  // pacing clock
  input  wire logic clk,
  // far-side sources
  output var logic  ext_pin,
  output var logic  xtal_clk,
  output var logic  cap_osc,
  output var logic  gate_pin
);
  // sources idle low, so a low level is always seen before the first rise
  initial begin
    ext_pin  = 1'b0;
    xtal_clk = 1'b0;
    cap_osc  = 1'b0;
    gate_pin = 1'b0;
  end
  // n full periods on one source, half period in clk cycles; ends low and stands still
  task automatic burst(input int which, input int n, input int half);
    for (int i = 0; i < 2 * n; i++) begin
      repeat (half) @(posedge clk);
      case (which)
        0: ext_pin <= ~ext_pin;
        1: xtal_clk <= ~xtal_clk;
        default: cap_osc <= ~cap_osc;
      endcase
    end
  endtask
  // gate pin level change at a clock edge
  task automatic set_gate(input logic v);
    @(posedge clk);
    gate_pin <= v;
  endtask
endmodule // gst_source_model
`default_nettype wire

//--- test/gst_timer_core_monitor.sv
// checker: port-level assertions for the gated timer core
`timescale 1ns/10ps
`default_nettype none
module gst_timer_core_monitor
  import gst_pkg::*;
#(
  parameter int CW = COUNT_WIDTH
) (
  // clock and reset
  input wire logic       clk,
  input wire logic       srst,
  // count access
  input wire logic       count_high_byte_we,
  input wire logic       count_low_byte_we,
  input wire logic [7:0] count_wdata,
  input wire logic [7:0] count_high_byte,
  input wire logic [7:0] count_low_byte,
  // control and gate
  input wire logic       counter_run,
  input wire logic [1:0] count_clock_select,
  input wire logic       async_mode,
  input wire logic       gate_count_enable,
  input wire logic       gate_polarity,
  input wire logic       gate_value,
  // flags
  input wire logic       overflow_clear,
  input wire logic       overflow_int_enable,
  input wire logic       gate_event_clear,
  input wire logic       sleep_mode,
  input wire logic       overflow_flag,
  input wire logic       overflow_irq,
  input wire logic       gate_event_flag,
  input wire logic       wake_request
);
  logic [15:0] cnt;  // joined count
  logic        wr;   // any byte write
  assign cnt = {count_high_byte, count_low_byte};
  assign wr  = count_high_byte_we | count_low_byte_we;
  logic        wake_cond;  // wake terms as the rule states them, for one-cycle lag check
  assign wake_cond = sleep_mode && overflow_irq && async_mode && (count_clock_select == CS_EXT);
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  // windows of several cycles absorb the sync and prescaler pipeline
  property p_step; !wr |=> (cnt == $past(cnt)) || (cnt == $past(cnt) + 16'h0001); endproperty
  a_step: assert property (p_step) else $error("count moved by more than one");
  property p_wr_lo; count_low_byte_we |=> count_low_byte == $past(count_wdata); endproperty
  a_wr_lo: assert property (p_wr_lo) else $error("low byte write lost");
  property p_wr_hi; count_high_byte_we |=> count_high_byte == $past(count_wdata); endproperty
  a_wr_hi: assert property (p_wr_hi) else $error("high byte write lost");
  property p_off; (!counter_run && !wr) [*3] |-> $stable(cnt); endproperty
  a_off: assert property (p_off) else $error("count moved while stopped");
  property p_hold;
    (counter_run && gate_count_enable && gate_value != gate_polarity && !wr) [*4] |-> $stable(cnt);
  endproperty
  a_hold: assert property (p_hold) else $error("count moved with gate closed");
  property p_wrap; (cnt == 16'hFFFF && !wr ##1 cnt == 16'h0000) |-> ##[0:1] overflow_flag; endproperty
  a_wrap: assert property (p_wrap) else $error("wrap without overflow flag");
  property p_sticky; overflow_flag && !overflow_clear |=> overflow_flag; endproperty
  a_sticky: assert property (p_sticky) else $error("overflow flag dropped");
  property p_irq; overflow_irq == (overflow_flag && overflow_int_enable); endproperty
  a_irq: assert property (p_irq) else $error("overflow request wrong");
  property p_gev; gate_event_flag && !gate_event_clear |=> gate_event_flag; endproperty
  a_gev: assert property (p_gev) else $error("gate event flag dropped");
  property p_wake;
    wake_request == $past(wake_cond);
  endproperty
  a_wake: assert property (p_wake) else $error("wake request wrong");
  c_irq: cover property (overflow_irq);
  c_wake: cover property (wake_request);
  c_gev: cover property ($rose(gate_event_flag));
endmodule // gst_timer_core_monitor
bind gst_timer_core gst_timer_core_monitor #(.CW(CW)) u_monitor (
  .clk, .srst, .count_high_byte_we, .count_low_byte_we, .count_wdata,
  .count_high_byte, .count_low_byte, .counter_run, .count_clock_select, .async_mode,
  .gate_count_enable, .gate_polarity, .gate_value, .overflow_clear, .overflow_int_enable,
  .gate_event_clear, .sleep_mode, .overflow_flag, .overflow_irq, .gate_event_flag, .wake_request
);
`default_nettype wire

//--- test/testbench.sv
// testbench: self-checking scenarios for the gated timer core
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import gst_pkg::*;
  logic clk = 1'b0, srst = 1'b1, hwe = 1'b0, lwe = 1'b0, run = 1'b0, xen = 1'b0;
  logic asy = 1'b0, gce = 1'b0, gpol = 1'b0, t0 = 1'b0, cmp1 = 1'b0, cmp2 = 1'b0;
  logic oclr = 1'b0, ien = 1'b0, gclr = 1'b0, slp = 1'b0;
  logic [7:0] wdat = 8'h00, hi, lo;
  logic [1:0] csel = 2'h0, psel = 2'h0, gsrc = 2'h0;
  logic gval, ovf, irq, gev, wake, ext_pin, xtal, cap, gpin;
  logic [15:0] cnt;
  int n_mismatch = 0, total_checks = 0;
  assign cnt = {hi, lo};
  always #20 clk = ~clk;
  gst_source_model src (.clk(clk), .ext_pin(ext_pin), .xtal_clk(xtal), .cap_osc(cap), .gate_pin(gpin));
  gst_timer_core uut (.clk(clk), .srst(srst), .count_high_byte_we(hwe), .count_low_byte_we(lwe),
    .count_wdata(wdat), .count_high_byte(hi), .count_low_byte(lo), .counter_run(run),
    .count_clock_select(csel), .crystal_osc_enable(xen), .prescale_select(psel), .async_mode(asy),
    .gate_count_enable(gce), .gate_polarity(gpol), .gate_source_select(gsrc), .gate_value(gval),
    .external_count_pin(ext_pin), .crystal_osc_clk(xtal), .cap_sense_osc(cap), .gate_input_pin(gpin),
    .tmr0_overflow(t0), .first_comparator_out(cmp1), .second_comparator_out(cmp2),
    .overflow_clear(oclr), .overflow_int_enable(ien), .gate_event_clear(gclr), .sleep_mode(slp),
    .overflow_flag(ovf), .overflow_irq(irq), .gate_event_flag(gev), .wake_request(wake));
  task automatic complete_run;
    if (n_mismatch == 0 && total_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error %s: expected %h, seen %h", what, exp, seen);
    end
  endtask
  // one-cycle byte write strobe
  task automatic wr(input logic h, input logic [7:0] d);
    @(posedge clk);
    if (h) hwe <= 1'b1;
    else lwe <= 1'b1;
    wdat <= d;
    @(posedge clk);
    hwe <= 1'b0;
    lwe <= 1'b0;
  endtask
  // one-cycle clear pulse: gate event when g, else overflow
  task automatic clr(input logic g);
    @(posedge clk);
    if (g) gclr <= 1'b1;
    else oclr <= 1'b1;
    @(posedge clk);
    gclr <= 1'b0;
    oclr <= 1'b0;
  endtask
  // count advance over cyc cycles (w < 0) or over a burst of n full periods (n rising edges) on source w
  task automatic meas(input int w, input int n, input int cyc, input string what);
    logic [15:0] c0;
    repeat (8) @(posedge clk);
    #1 c0 = cnt;
    if (w < 0) repeat (cyc) @(posedge clk);
    else src.burst(w, n, 6);
    if (w >= 0) repeat (8) @(posedge clk);
    #1 chk(what, cnt - c0, 16'(n));
  endtask
  task automatic t_write;
    wr(1'b1, 8'hA5);
    wr(1'b0, 8'h3C);
    @(posedge clk);
    #1 chk("byte write", cnt, 16'hA53C);
    meas(-1, 0, 20, "stopped");
  endtask
  task automatic t_rate;
    @(posedge clk);
    run <= 1'b1;
    meas(-1, 100, 400, "instruction rate");
    csel <= CS_SYS;
    meas(-1, 100, 100, "system rate");
    for (int p = 1; p < 4; p++) begin
      psel <= 2'(p);
      meas(-1, 160 >> p, 160, "prescale");
    end
    wr(1'b0, 8'h00);
    repeat (7) @(posedge clk);
    #1 chk("prescale cleared", {8'h00, lo}, 16'h0000);
    @(posedge clk);
    #1 chk("prescale first tick", {8'h00, lo}, 16'h0001);
    psel <= 2'h0;
    csel <= CS_EXT;
    meas(0, 5, 0, "external pin");
    xen <= 1'b1;
    meas(1, 3, 0, "crystal");
    csel <= CS_CAP;
    meas(2, 4, 0, "cap osc");
  endtask
  task automatic t_gate;
    @(posedge clk);
    csel <= CS_SYS;
    gce <= 1'b1;
    gpol <= 1'b1;
    cmp1 <= 1'b1;
    xen <= 1'b0;
    src.set_gate(1'b1);
    for (int s = 0; s < 4; s++) begin
      gsrc <= 2'(s);
      meas(-1, s[0] ? 0 : 50, 50, "gate source");
      chk("gate value", 16'(gval), 16'(!s[0]));
    end
    gpol <= 1'b0;
    meas(-1, 50, 50, "low polarity");
    // timer0 level high against low polarity closes the gate
    gsrc <= GS_TMR0;
    t0 <= 1'b1;
    meas(-1, 0, 50, "timer0 gate");
    chk("timer0 gate value", 16'(gval), 16'h0001);
    gsrc <= GS_PIN;
    gpol <= 1'b1;
    repeat (8) @(posedge clk);
    clr(1'b1);
    #1 chk("gate event clear", 16'(gev), 16'h0000);
    src.set_gate(1'b0);
    meas(-1, 0, 50, "gate closed");
    chk("gate event", 16'(gev), 16'h0001);
    run <= 1'b0;
    src.set_gate(1'b1);
    meas(-1, 0, 50, "run off gated");
    gce <= 1'b0;
  endtask
  task automatic t_ovf;
    int i;
    csel <= CS_SYS;
    ien <= 1'b1;
    clr(1'b0);
    wr(1'b1, 8'hFF);
    wr(1'b0, 8'hF0);
    run <= 1'b1;
    for (i = 0; i < 64 && ovf !== 1'b1; i++) begin
      @(posedge clk);
      #1;
    end
    if (i == 64) chk("overflow wait", 16'h0000, 16'h0001);
    chk("wrap count", 16'(cnt < 16'h0004), 16'h0001);
    chk("overflow request", 16'(irq), 16'h0001);
    @(posedge clk);
    run <= 1'b0;
    csel <= CS_EXT;
    slp <= 1'b1;
    asy <= 1'b1;
    // drop the flag left by the first wrap so the wake below comes from the new one
    clr(1'b0);
    wr(1'b1, 8'hFF);
    wr(1'b0, 8'hFF);
    #1 chk("wake before wrap", 16'(wake), 16'h0000);
    run <= 1'b1;
    meas(0, 1, 0, "wrap edge");
    chk("wake", 16'(wake), 16'h0001);
    chk("overflow sticky", 16'(ovf), 16'h0001);
    asy <= 1'b0;
    repeat (2) @(posedge clk);
    #1 chk("wake sync", 16'(wake), 16'h0000);
    clr(1'b0);
    #1 chk("overflow clear", 16'(ovf), 16'h0000);
  endtask
  initial begin
    repeat (100000) @(posedge clk);
    n_mismatch++;
    complete_run;
  end
  initial begin
    repeat (10) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    #1 chk("reset", cnt | {13'h0000, ovf, gev, wake}, 16'h0000);
    t_write;
    t_rate;
    t_gate;
    t_ovf;
    complete_run;
  end
endmodule // testbench
`default_nettype wire
